// File: ofrw_defines.vh
// constants for the fault retry sequencer and output warning limits
`ifndef OFRW_DEFINES_VH
`define OFRW_DEFINES_VH
`define OFRW_CMD_OV_WARN     8'h42
`define OFRW_CMD_UV_WARN     8'h43
`define OFRW_CMD_UV_RESP     8'h45
`define OFRW_CMD_TIME_UNIT   8'hd2
`define OFRW_RESP_HI         7
`define OFRW_RESP_LO         6
`define OFRW_RETRY_HI        5
`define OFRW_RETRY_LO        3
`define OFRW_DELAY_HI        2
`define OFRW_DELAY_LO        0
`define OFRW_RESP_IGNORE     2'h0
`define OFRW_RESP_DELAY      2'h1
`define OFRW_RESP_SHUTDOWN   2'h2
`define OFRW_RESP_WHILE      2'h3
`define OFRW_RETRY_NONE      3'h0
`define OFRW_RETRY_FOREVER   3'h7
`define OFRW_OV_WARN_RST     16'hffff
`define OFRW_UV_WARN_RST     16'h0000
`define OFRW_UV_RESP_RST     8'h80
`define OFRW_TIME_UNIT_RST   8'h01
// one delay time unit is this many ns per count in the time-unit register, rounded up to whole core_clk cycles
`define OFRW_UNIT_NS         1000
`define OFRW_CLK_NS          25
`define OFRW_UNIT_CYC        ((`OFRW_UNIT_NS + `OFRW_CLK_NS - 1) / `OFRW_CLK_NS)
`endif

// File: ofrw_delay_timer.v
// delay timer counting decoded delay time units
`timescale 1ns/1ps
`include "ofrw_defines.vh"
module ofrw_delay_timer (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // control
  input  wire        start,
  input  wire [2:0]  delay_code,
  input  wire [7:0]  unit_len,
  // status
  output reg         done_r
);
  reg [5:0]  tick_r;
  reg [7:0]  sub_r;
  reg [7:0]  units_r;
  reg        run_r;
  wire       tick_end = (tick_r == `OFRW_UNIT_CYC - 1);
  wire       sub_end  = tick_end && (sub_r + 8'h01 >= unit_len);

  // power-of-two decode of the delay field
  function [7:0] dec_units;
    input [2:0] code;
    begin
      dec_units = 8'h01 << code;
    end
  endfunction

  always @(posedge core_clk) begin
    if (rst) begin
      tick_r  <= 6'h00;
      sub_r   <= 8'h00;
      units_r <= 8'h00;
      run_r   <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        // first tick is one cycle short: the done pulse is taken a cycle late, so the
        // next start lands exactly one period after this one
        tick_r  <= 6'h01;
        sub_r   <= 8'h00;
        units_r <= dec_units(delay_code) - 8'h01;
        run_r   <= 1'b1;
      end else if (run_r) begin
        tick_r <= tick_end ? 6'h00 : tick_r + 6'h01;
        if (sub_end) begin
          sub_r <= 8'h00;
          if (units_r == 8'h00) begin
            run_r  <= 1'b0;
            done_r <= 1'b1;
          end else begin
            units_r <= units_r - 8'h01;
          end
        end else if (tick_end) begin
          sub_r <= sub_r + 8'h01;
        end
      end
    end
  end
endmodule

// File: ofrw_top.v
// fault response retry sequencer with output voltage warning limit registers
// Notes on behaviour
// - retry codes 1 to 6 give exactly that many restart attempts after a fault shutdown.
// - once all permitted restarts fail the output stays off until the fault is cleared.
// - restart attempts start one delay count times the time unit apart.
// - retry code 7 retries without limit until turned off, bias loss or another fault.
// - delay field values 0 to 7 decode to 1, 2, 4 up to 128 time units.
// - the delay count is the run-on time after a fault or the gap between restarts by mode.
// - the length of one time unit comes from the register at command 0xd2.
// - command 0x42 is a 16-bit read/write over-voltage warning threshold.
// - command 0x43 is a 16-bit read/write under-voltage warning threshold.
// - response 0 ignores, 1 runs on then retries, 2 shuts down then retries, 3 follows fault.
// - retry code 0 never restarts and code 1 restarts once.
// - status clear, clear-faults, reset, off then on, or bias loss clear a latched fault.
`timescale 1ns/1ps
`include "ofrw_defines.vh"
module ofrw_top (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // register port from the management bus decoder
  input  wire [7:0]  cmd_code,
  input  wire        wr_stb,
  input  wire [15:0] wr_data,
  input  wire        rd_stb,
  output reg  [15:0] rd_data_r,
  output reg         rd_valid_r,
  output reg         rd_err_r,
  // power stage
  input  wire        fault_in,
  input  wire        other_fault,
  input  wire        restart_ok,
  input  wire        output_on_req,
  input  wire        bias_ok,
  input  wire        clear_faults,
  input  wire        status_clear,
  input  wire [15:0] vout_meas,
  output reg         output_en_r,
  output reg         fault_latched_r,
  output reg         restarting_r,
  output reg         ov_warn_r,
  output reg         uv_warn_r
);
  localparam [2:0] ST_RUN   = 3'd0;
  localparam [2:0] ST_RUNON = 3'd1;
  localparam [2:0] ST_WAIT  = 3'd2;
  localparam [2:0] ST_TRY   = 3'd3;
  localparam [2:0] ST_LATCH = 3'd4;
  localparam [2:0] ST_HOLD  = 3'd5;

  reg [15:0] ov_warn_lim_r;
  reg [15:0] uv_warn_lim_r;
  reg [7:0]  resp_r;
  reg [7:0]  unit_r;
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [2:0]  tries_r;
  reg        on_req_d_r;
  reg        tmr_start;
  wire       tmr_done;

  wire [1:0] mode       = resp_r[`OFRW_RESP_HI:`OFRW_RESP_LO];
  wire [2:0] retry_code = resp_r[`OFRW_RETRY_HI:`OFRW_RETRY_LO];
  wire [2:0] delay_code = resp_r[`OFRW_DELAY_HI:`OFRW_DELAY_LO];
  // an off-to-on cycle of the output request also clears a latched fault
  wire       cycle_on   = output_on_req && !on_req_d_r;
  wire       fault_clr  = status_clear || clear_faults || cycle_on || !bias_ok;
  wire       cmd_off    = !output_on_req || !bias_ok || other_fault;
  wire       more_tries = (retry_code == `OFRW_RETRY_FOREVER) || (tries_r < retry_code);

  ofrw_delay_timer u_timer (
    .core_clk   (core_clk),
    .rst        (rst),
    .start      (tmr_start),
    .delay_code (delay_code),
    .unit_len   (unit_r),
    .done_r     (tmr_done)
  );

  // registers
  always @(posedge core_clk) begin
    if (rst) begin
      ov_warn_lim_r <= `OFRW_OV_WARN_RST;
      uv_warn_lim_r <= `OFRW_UV_WARN_RST;
      resp_r        <= `OFRW_UV_RESP_RST;
      unit_r        <= `OFRW_TIME_UNIT_RST;
    end else if (wr_stb) begin
      if (cmd_code == `OFRW_CMD_OV_WARN) begin
        ov_warn_lim_r <= wr_data;
      end else if (cmd_code == `OFRW_CMD_UV_WARN) begin
        uv_warn_lim_r <= wr_data;
      end else if (cmd_code == `OFRW_CMD_UV_RESP) begin
        resp_r <= wr_data[7:0];
      end else if (cmd_code == `OFRW_CMD_TIME_UNIT) begin
        unit_r <= wr_data[7:0];
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      rd_data_r  <= 16'h0000;
      rd_valid_r <= 1'b0;
      rd_err_r   <= 1'b0;
    end else begin
      rd_valid_r <= rd_stb;
      rd_err_r   <= 1'b0;
      rd_data_r  <= 16'h0000;
      if (rd_stb) begin
        if (cmd_code == `OFRW_CMD_OV_WARN) begin
          rd_data_r <= ov_warn_lim_r;
        end else if (cmd_code == `OFRW_CMD_UV_WARN) begin
          rd_data_r <= uv_warn_lim_r;
        end else if (cmd_code == `OFRW_CMD_UV_RESP) begin
          rd_data_r <= {8'h00, resp_r};
        end else if (cmd_code == `OFRW_CMD_TIME_UNIT) begin
          rd_data_r <= {8'h00, unit_r};
        end else begin
          rd_err_r <= 1'b1;
        end
      end
    end
  end

  // fault sequencer
  always @* begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (fault_in && output_on_req && bias_ok) begin
          if (mode == `OFRW_RESP_DELAY) begin
            state_nxt = ST_RUNON;
            tmr_start = 1'b1;
          end else if (mode == `OFRW_RESP_SHUTDOWN) begin
            state_nxt = ST_WAIT;
            tmr_start = 1'b1;
          end else if (mode == `OFRW_RESP_WHILE) begin
            state_nxt = ST_HOLD;
          end
        end
      end
      ST_RUNON: begin
        if (!fault_in) begin
          state_nxt = ST_RUN;
        end else if (tmr_done) begin
          state_nxt = ST_WAIT;
          tmr_start = 1'b1;
        end
      end
      ST_WAIT: begin
        if (!more_tries) begin
          state_nxt = ST_LATCH;
        end else if (tmr_done) begin
          state_nxt = ST_TRY;
          tmr_start = 1'b1;
        end
      end
      ST_TRY: begin
        // the gap timer keeps running from the start of this attempt
        if (restart_ok) begin
          state_nxt = ST_RUN;
        end else if (tmr_done) begin
          // an attempt that has not come up by the end of its gap has failed
          if (more_tries) begin
            tmr_start = 1'b1;
          end else begin
            state_nxt = ST_LATCH;
          end
        end
      end
      ST_LATCH: begin
        if (fault_clr) begin
          state_nxt = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!fault_in) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    if ((state_r == ST_WAIT || state_r == ST_TRY) && cmd_off) begin
      state_nxt = ST_LATCH;
      tmr_start = 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_r         <= ST_RUN;
      tries_r         <= 3'h0;
      // idle level of the on request is on, so no false off-to-on edge follows reset
      on_req_d_r      <= 1'b1;
      output_en_r     <= 1'b0;
      fault_latched_r <= 1'b0;
      restarting_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      on_req_d_r <= output_on_req;
      if (state_nxt == ST_RUN || state_nxt == ST_LATCH) begin
        tries_r <= 3'h0;
      end else if (tmr_start && state_nxt == ST_TRY && tries_r != 3'h7) begin
        tries_r <= tries_r + 3'h1;
      end
      output_en_r <= output_on_req && bias_ok &&
                     (state_nxt == ST_RUN || state_nxt == ST_RUNON || state_nxt == ST_TRY);
      fault_latched_r <= (state_nxt == ST_LATCH);
      // low in the cycle each attempt begins, so back-to-back attempts show as separate pulses
      restarting_r    <= (state_nxt == ST_TRY) && !tmr_start;
    end
  end

  // warnings
  always @(posedge core_clk) begin
    if (rst) begin
      ov_warn_r <= 1'b0;
      uv_warn_r <= 1'b0;
    end else begin
      ov_warn_r <= (vout_meas > ov_warn_lim_r);
      uv_warn_r <= (vout_meas < uv_warn_lim_r);
    end
  end
endmodule

// File: ofrw_props.sv
// assertion checker for the register port and the fault latch
`timescale 1ns/1ps
module ofrw_props (
  // watched ports
  input wire        core_clk,
  input wire        rst,
  input wire [7:0]  cmd_code,
  input wire        rd_stb,
  input wire        clear_faults,
  input wire [15:0] rd_data_r,
  input wire        rd_valid_r,
  input wire        rd_err_r,
  input wire        output_en_r,
  input wire        fault_latched_r,
  input wire        restarting_r
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rd_ans; rd_stb |=> rd_valid_r; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_one; !rd_stb |=> !rd_valid_r; endproperty
  a_rd_one: assert property (p_rd_one) else $error("read answer without strobe");
  property p_err;
    rd_valid_r |-> rd_err_r == !($past(cmd_code) inside {8'h42, 8'h43, 8'h45, 8'hd2});
  endproperty
  a_err: assert property (p_err) else $error("error flag wrong for code");
  property p_rd_zero; !rd_valid_r |-> rd_data_r == 16'h0000; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data not idle");
  property p_err_zero; rd_err_r |-> rd_valid_r && rd_data_r == 16'h0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read data nonzero");
  property p_lat_off; fault_latched_r |-> !output_en_r && !restarting_r; endproperty
  a_lat_off: assert property (p_lat_off) else $error("output on while latched");
  property p_clr; fault_latched_r && clear_faults |=> !fault_latched_r; endproperty
  a_clr: assert property (p_clr) else $error("latch not cleared");
  property p_try_gap; $rose(restarting_r) |=> !$rose(restarting_r) [*8]; endproperty
  a_try_gap: assert property (p_try_gap) else $error("restart attempts too close");
endmodule

// File: ofrw_stage_model.sv
// power stage model that lets the n-th restart attempt succeed
`timescale 1ns/1ps
module ofrw_stage_model (
  // clock
  input  wire       core_clk,
  // sequencer side
  input  wire       restarting_r,
  input  wire [2:0] ok_after,
  output reg        restart_ok = 1'b0
);
  reg       was_r = 1'b0;
  reg [2:0] n_r   = 3'h0;
  wire      rise  = restarting_r && !was_r;
  // zero means the stage never comes up, so every attempt fails
  always @(negedge core_clk) begin
    if (ok_after == 3'h0)
      n_r <= 3'h0;
    else if (rise)
      n_r <= n_r + 3'h1;
    was_r <= restarting_r;
    // the attempt under way is counted together with the one that has just begun
    restart_ok <= restarting_r && ok_after != 3'h0 && (rise ? n_r + 3'h1 : n_r) >= ok_after;
  end
endmodule

// File: ofrw_tb.sv
// self-checking bench for the fault retry sequencer and warning limits
`timescale 1ns/1ps
`include "ofrw_defines.vh"
module testbench;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  cmd_code = 8'h00;
  reg         wr_stb = 1'b0;
  reg  [15:0] wr_data = 16'h0000;
  reg         rd_stb = 1'b0;
  reg         fault_in = 1'b0;
  reg         other_fault = 1'b0;
  reg         output_on_req = 1'b1;
  reg         bias_ok = 1'b1;
  reg         clear_faults = 1'b0;
  reg         status_clear = 1'b0;
  reg  [15:0] vout_meas = 16'h1000;
  reg  [2:0]  ok_after = 3'h0;
  reg         prev = 1'b0;
  wire [15:0] rd_data_r;
  wire        rd_valid_r, rd_err_r, restart_ok, output_en_r, fault_latched_r;
  wire        restarting_r, ov_warn_r, uv_warn_r;
  int         n_fail = 0, checks_done = 0, cyc = 0, t_last = 0, gap = 0, n_try = 0, i, c;
  int         n0 = 0;
  ofrw_top i_dut (
    .core_clk        (core_clk),
    .rst             (rst),
    .cmd_code        (cmd_code),
    .wr_stb          (wr_stb),
    .wr_data         (wr_data),
    .rd_stb          (rd_stb),
    .rd_data_r       (rd_data_r),
    .rd_valid_r      (rd_valid_r),
    .rd_err_r        (rd_err_r),
    .fault_in        (fault_in),
    .other_fault     (other_fault),
    .restart_ok      (restart_ok),
    .output_on_req   (output_on_req),
    .bias_ok         (bias_ok),
    .clear_faults    (clear_faults),
    .status_clear    (status_clear),
    .vout_meas       (vout_meas),
    .output_en_r     (output_en_r),
    .fault_latched_r (fault_latched_r),
    .restarting_r    (restarting_r),
    .ov_warn_r       (ov_warn_r),
    .uv_warn_r       (uv_warn_r)
  );
  ofrw_stage_model i_stage (
    .core_clk     (core_clk),
    .restarting_r (restarting_r),
    .ok_after     (ok_after),
    .restart_ok   (restart_ok)
  );
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    prev <= restarting_r;
    if (restarting_r && !prev) begin
      n_try <= n_try + 1;
      gap <= cyc - t_last;
      t_last <= cyc;
    end
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(negedge core_clk);
    cmd_code = a;
    wr_data = d;
    wr_stb = 1'b1;
    @(negedge core_clk);
    wr_stb = 1'b0;
  endtask
  task rdc(input [7:0] a, input [15:0] e, input er);
    @(negedge core_clk);
    cmd_code = a;
    rd_stb = 1'b1;
    @(negedge core_clk);
    rd_stb = 1'b0;
    chk("rd_data", rd_data_r, e);
    chk("rd_err", {15'h0, rd_err_r}, {15'h0, er});
  endtask
  task cyc_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task clr(input sel);
    @(negedge core_clk);
    clear_faults = sel;
    status_clear = !sel;
    @(negedge core_clk);
    clear_faults = 1'b0;
    status_clear = 1'b0;
    cyc_n(2);
    chk("latched", {15'h0, fault_latched_r, output_en_r}, 16'h0001);
  endtask
  task wait_lat(input int n);
    for (i = 0; i < n && fault_latched_r !== 1'b1; i++) @(negedge core_clk);
    if (i == n) begin
      n_fail++;
      report_and_stop;
    end
  endtask
  initial begin
    #2000000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    cyc_n(10);
    rst = 1'b0;
    rdc(8'h42, `OFRW_OV_WARN_RST, 1'b0);
    rdc(8'h43, `OFRW_UV_WARN_RST, 1'b0);
    rdc(8'hd2, {8'h00, `OFRW_TIME_UNIT_RST}, 1'b0);
    rdc(8'h50, 16'h0000, 1'b1);
    wr(8'h42, 16'h2000);
    wr(8'h43, 16'h0800);
    rdc(8'h42, 16'h2000, 1'b0);
    rdc(8'h43, 16'h0800, 1'b0);
    vout_meas = 16'h2001;
    cyc_n(3);
    chk("warn_hi", {14'h0, ov_warn_r, uv_warn_r}, 16'h0002);
    vout_meas = 16'h07ff;
    cyc_n(3);
    chk("warn_lo", {14'h0, ov_warn_r, uv_warn_r}, 16'h0001);
    vout_meas = 16'h1000;
    // every response mode with no retry and a one-unit delay
    for (c = 0; c < 4; c++) begin
      wr(8'h45, {8'h00, c[1:0], 6'h00});
      fault_in = 1'b1;
      cyc_n(20);
      chk("run_on", {15'h0, output_en_r}, {15'h0, c < 2});
      cyc_n(40);
      chk("latch", {15'h0, fault_latched_r}, {15'h0, c == 1 || c == 2});
      fault_in = 1'b0;
      cyc_n(3);
      chk("out_after", {15'h0, output_en_r}, {15'h0, c == 0 || c == 3});
      clr(c[0]);
    end
    for (c = 1; c < 7; c++) begin
      wr(8'hd2, c > 4 ? 16'h0002 : 16'h0001);
      wr(8'h45, {8'h00, 2'b10, c[2:0], 3'(c % 3)});
      n0 = n_try;
      fault_in = 1'b1;
      wait_lat(3000);
      chk("tries", 16'(n_try - n0), c[15:0]);
      if (c > 1)
        chk("gap", gap[15:0], 16'((1 << (c % 3)) * 40 * (c > 4 ? 2 : 1)));
      fault_in = 1'b0;
      clr(c[0]);
    end
    wr(8'hd2, 16'h0001);
    wr(8'h45, 16'h00b8);
    n0 = n_try;
    fault_in = 1'b1;
    cyc_n(400);
    chk("forever", {14'h0, fault_latched_r, (n_try - n0) > 5}, 16'h0001);
    output_on_req = 1'b0;
    wait_lat(50);
    fault_in = 1'b0;
    output_on_req = 1'b1;
    cyc_n(3);
    chk("on_clear", {15'h0, fault_latched_r}, 16'h0000);
    wr(8'h45, 16'h0098);
    ok_after = 3'h2;
    n0 = n_try;
    fault_in = 1'b1;
    cyc_n(50);
    fault_in = 1'b0;
    cyc_n(200);
    chk("recover", {14'(n_try - n0), fault_latched_r, output_en_r}, 16'h0009);
    // another fault stops endless retries; bias loss then clears the latch
    ok_after = 3'h0;
    wr(8'h45, 16'h00b8);
    fault_in = 1'b1;
    cyc_n(100);
    other_fault = 1'b1;
    wait_lat(50);
    chk("other_off", {15'h0, output_en_r}, 16'h0000);
    other_fault = 1'b0;
    fault_in = 1'b0;
    bias_ok = 1'b0;
    cyc_n(3);
    chk("bias_clr", {15'h0, fault_latched_r}, 16'h0000);
    bias_ok = 1'b1;
    // reset in mid-run clears a latched fault and restores the limits
    wr(8'h45, 16'h0080);
    fault_in = 1'b1;
    wait_lat(50);
    rst = 1'b1;
    cyc_n(2);
    rst = 1'b0;
    fault_in = 1'b0;
    cyc_n(2);
    chk("rst_clr", {15'h0, fault_latched_r}, 16'h0000);
    rdc(8'h42, `OFRW_OV_WARN_RST, 1'b0);
    report_and_stop;
  end
endmodule
bind ofrw_top ofrw_props i_props (
  .core_clk        (core_clk),
  .rst             (rst),
  .cmd_code        (cmd_code),
  .rd_stb          (rd_stb),
  .clear_faults    (clear_faults),
  .rd_data_r       (rd_data_r),
  .rd_valid_r      (rd_valid_r),
  .rd_err_r        (rd_err_r),
  .output_en_r     (output_en_r),
  .fault_latched_r (fault_latched_r),
  .restarting_r    (restarting_r)
);
